// ==== design/volume_ctrl_defs.svh ====
`ifndef VOLUME_CTRL_DEFS_SVH
`define VOLUME_CTRL_DEFS_SVH
// Function
// - Thirty-one levels, 20 dB down to -40 dB
// - Down press lowers one 2 dB step
// - Up press raises one 2 dB step
// - Held button repeats once per step tick
// - Internal step clock, external clock overrides
// - Level kept through shutdown on memory supply
// - Memory supply low loads -10 dB default
// - Input select high routes phones, else line
// - Config high: single-ended, 6 dB cut
// - Single-ended floats negative outputs, bridged drives
// - Shutdown stops all except beep detection; the code stops only ampEnable, the negative outputs and the buttons
// - Beep mode on square wave at beep input

// Core clock
`define CORE_CLK_PERIOD_NS  10

// Internal oscillator period and activity windows, in their own units
`define STEP_PERIOD_MS      50
`define EXT_CLK_TIMEOUT_US  1000
`define BEEP_TIMEOUT_MS     10
`define STEP_PERIOD_CYCLES  (`STEP_PERIOD_MS * 1000000 / `CORE_CLK_PERIOD_NS)
`define EXT_TIMEOUT_CYCLES  (`EXT_CLK_TIMEOUT_US * 1000 / `CORE_CLK_PERIOD_NS)
`define BEEP_TIMEOUT_CYCLES (`BEEP_TIMEOUT_MS * 1000000 / `CORE_CLK_PERIOD_NS)

// Volume levels: index 0 is -40 dB, index 30 is +20 dB
`define LEVEL_TOP      5'h1e
`define LEVEL_BOTTOM   5'h00
`define LEVEL_DEFAULT  5'h0f
`define LEVEL_ONE      5'h01
`define GAIN_BOTTOM_DB 8'hd8
`define GAIN_SE_CUT_DB 8'h06

// Positions of the synchronised pins
`define PIN_UP     0
`define PIN_DOWN   1
`define PIN_INSEL  2
`define PIN_OUTCFG 3
`define PIN_SDN    4
`define PIN_MEMOK  5
`define PIN_COUNT  6

// Register map and status fields
`define REG_STATUS      8'h00
`define REG_STEP_PERIOD 8'h04
`define ST_LEVEL_LSB    0
`define ST_LEVEL_MSB    4
`define ST_SHUTDOWN     5
`define ST_SINGLE       6
`define ST_PHONES       7
`define ST_BEEP         8
`define ST_EXTCLK       9
`define ST_MEMOK        10
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// ==== design/volume_ctrl_pkg.sv ====
package volume_ctrl_pkg;
	typedef logic [4:0] level_t;
	typedef enum logic [1:0] {DIR_NONE, DIR_UP, DIR_DOWN} step_dir_e;
endpackage

// ==== design/activity_detector.sv ====
`timescale 1ns/10ps
// Synchronises a pin, flags its rising edges and reports recent activity
module activity_detector #(
	parameter int TIMEOUT_CYCLES = 1000
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic pinIn,
	output logic      risePulse,
	output logic      active
);
	logic        meta;
	logic        sync;
	logic        last;
	logic [31:0] idleCnt;
	wire  logic  idleDone = (idleCnt >= 32'(TIMEOUT_CYCLES - 1));

	if (TIMEOUT_CYCLES < 2) begin : g_chk
		$error("activity_detector: TIMEOUT_CYCLES below 2");
	end

	assign risePulse = sync & ~last;

	// Two-stage synchroniser, then edge memory and idle timer
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			meta    <= 1'b0;
			sync    <= 1'b0;
			last    <= 1'b0;
			idleCnt <= 32'h0;
			active  <= 1'b0;
		end else begin
			meta <= pinIn;
			sync <= meta;
			last <= sync;
			if (risePulse) begin
				idleCnt <= 32'h0;
				active  <= 1'b1; // An edge wins over the timeout
			end else if (idleDone) begin
				active <= 1'b0;
			end else begin
				idleCnt <= idleCnt + 32'h1;
			end
		end
	end
endmodule // activity_detector

// ==== design/stepped_volume_control.sv ====
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "volume_ctrl_defs.svh"
// Stepped volume, input and output mode control with AXI4-Lite status access
module stepped_volume_control #(
	parameter int STEP_PERIOD_CYCLES  = `STEP_PERIOD_CYCLES,
	parameter int EXT_TIMEOUT_CYCLES  = `EXT_TIMEOUT_CYCLES,
	parameter int BEEP_TIMEOUT_CYCLES = `BEEP_TIMEOUT_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        volumeUpN,
	input  wire logic        volumeDownN,
	input  wire logic        stepClockPin,
	input  wire logic        inputSelect,
	input  wire logic        outputConfig,
	input  wire logic        shutdownN,
	input  wire logic        memorySupplyOk,
	input  wire logic        beepInput,
	output logic [4:0]       volumeLevel,
	output logic [7:0]       gainDb,
	output logic             phonesSelected,
	output logic             lineSelected,
	output logic             singleEndedMode,
	output logic             bridgedMode,
	output logic             leftNegativeOutputEn,
	output logic             rightNegativeOutputEn,
	output logic             ampEnable,
	output logic             beepMode,
	output logic             extClockInUse
);
	logic [`PIN_COUNT-1:0]       pinMeta;
	logic [`PIN_COUNT-1:0]       pinSync;
	volume_ctrl_pkg::level_t     level;
	volume_ctrl_pkg::level_t     next_level;
	volume_ctrl_pkg::step_dir_e  heldDir;
	volume_ctrl_pkg::step_dir_e  prevDir;
	logic                        armed;
	logic [31:0]                 oscCnt;
	logic [31:0]                 stepPeriod;
	logic                        extRise;
	logic                        extActive;
	logic                        beepRise;
	logic                        beepActive;
	logic                        awHeld;
	logic [7:0]                  awAddrQ;
	logic                        wHeld;
	logic [31:0]                 wDataQ;
	logic [3:0]                  wStrbQ;
	logic [31:0]                 statusWord;
	logic [7:0]                  next_gainDb;

	if (STEP_PERIOD_CYCLES < 2) begin : g_chk
		$error("stepped_volume_control: STEP_PERIOD_CYCLES below 2");
	end

	// Pins from outside pass two flip-flops before any logic reads them
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pinMeta <= '0;
			pinSync <= '0;
		end else begin
			pinMeta <= {memorySupplyOk, shutdownN, outputConfig, inputSelect,
			            volumeDownN, volumeUpN};
			pinSync <= pinMeta;
		end
	end

	// Synchronised levels, buttons active low and ignored in shutdown
	wire logic memOk    = pinSync[`PIN_MEMOK];
	wire logic running  = pinSync[`PIN_SDN];
	wire logic seSel    = pinSync[`PIN_OUTCFG];
	wire logic upHeld   = ~pinSync[`PIN_UP] & running;
	wire logic downHeld = ~pinSync[`PIN_DOWN] & running;

	// Clock pin and beep input each get their own activity detector
	activity_detector #(.TIMEOUT_CYCLES(EXT_TIMEOUT_CYCLES)) u_ext_clk (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.pinIn     (stepClockPin),
		.risePulse (extRise),
		.active    (extActive)
	);
	activity_detector #(.TIMEOUT_CYCLES(BEEP_TIMEOUT_CYCLES)) u_beep (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.pinIn     (beepInput),
		.risePulse (beepRise),
		.active    (beepActive)
	);

	// Step tick: external clock edges while it toggles, else the oscillator
	wire logic oscTick  = (oscCnt + 32'h1 >= stepPeriod);
	wire logic stepTick = extActive ? extRise : oscTick;

	// Internal oscillator, held in reset while the external clock runs
	always_ff @(posedge core_clk) begin
		if (!rst_n || extActive || oscTick) begin
			oscCnt <= 32'h0;
		end else begin
			oscCnt <= oscCnt + 32'h1;
		end
	end

	// Held direction; both buttons together count as none
	always_comb begin
		case ({upHeld, downHeld})
			2'b10:   heldDir = volume_ctrl_pkg::DIR_UP;
			2'b01:   heldDir = volume_ctrl_pkg::DIR_DOWN;
			default: heldDir = volume_ctrl_pkg::DIR_NONE;
		endcase
	end

	// A new direction steps once; repeats start after one full tick
	wire logic pressEdge = (heldDir != prevDir) &&
	                       (heldDir != volume_ctrl_pkg::DIR_NONE);
	wire logic doStep    = pressEdge | (armed & stepTick);
	wire logic stepUp    = doStep && (heldDir == volume_ctrl_pkg::DIR_UP);
	wire logic stepDown  = doStep && (heldDir == volume_ctrl_pkg::DIR_DOWN);
	wire logic atTop     = (level == `LEVEL_TOP);
	wire logic atBottom  = (level == `LEVEL_BOTTOM);

	// Press tracking and repeat arming
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prevDir <= volume_ctrl_pkg::DIR_NONE;
			armed   <= 1'b0;
		end else begin
			prevDir <= heldDir;
			if (pressEdge || heldDir == volume_ctrl_pkg::DIR_NONE) begin
				armed <= 1'b0;
			end else if (stepTick) begin
				armed <= 1'b1;
			end
		end
	end

	// Next level: supply loss wins, then saturating single steps
	always_comb begin
		if (!memOk) begin
			next_level = `LEVEL_DEFAULT;
		end else if (stepUp && !atTop) begin
			next_level = level + `LEVEL_ONE;
		end else if (stepDown && !atBottom) begin
			next_level = level - `LEVEL_ONE;
		end else begin
			next_level = level;
		end
	end

	// Effective gain in dB, two's complement, 6 dB less when single-ended
	assign next_gainDb = 8'({2'b00, level, 1'b0}) + `GAIN_BOTTOM_DB
	                     - (seSel ? `GAIN_SE_CUT_DB : 8'h00);

	// Level storage and registered mode outputs
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			level                 <= `LEVEL_DEFAULT;
			gainDb                <= 8'h00;
			phonesSelected        <= 1'b0;
			lineSelected          <= 1'b0;
			singleEndedMode       <= 1'b0;
			bridgedMode           <= 1'b0;
			leftNegativeOutputEn  <= 1'b0;
			rightNegativeOutputEn <= 1'b0;
			ampEnable             <= 1'b0;
		end else begin
			level                 <= next_level;
			gainDb                <= next_gainDb;
			phonesSelected        <= pinSync[`PIN_INSEL];
			lineSelected          <= ~pinSync[`PIN_INSEL];
			singleEndedMode       <= seSel;
			bridgedMode           <= ~seSel;
			leftNegativeOutputEn  <= ~seSel & running;
			rightNegativeOutputEn <= ~seSel & running;
			ampEnable             <= running;
		end
	end

	assign volumeLevel   = level;
	assign beepMode      = beepActive;
	assign extClockInUse = extActive;

	// Status word seen by software
	always_comb begin
		statusWord = 32'h0;
		statusWord[`ST_LEVEL_MSB:`ST_LEVEL_LSB] = level;
		statusWord[`ST_SHUTDOWN] = ~running;
		statusWord[`ST_SINGLE]   = seSel;
		statusWord[`ST_PHONES]   = pinSync[`PIN_INSEL];
		statusWord[`ST_BEEP]     = beepActive;
		statusWord[`ST_EXTCLK]   = extActive;
		statusWord[`ST_MEMOK]    = memOk;
	end

	// AXI4-Lite handshakes: address and data taken in either order
	assign awready = ~awHeld;
	assign wready  = ~wHeld;
	assign arready = ~rvalid;
	wire logic doWrite  = awHeld & wHeld & ~bvalid;
	wire logic wrPeriod = (awAddrQ == `REG_STEP_PERIOD);
	wire logic doRead   = arvalid & arready;
	wire logic rdStatus = (araddr == `REG_STATUS);
	wire logic rdPeriod = (araddr == `REG_STEP_PERIOD);

	// Write side: capture, apply by byte lane, respond
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			awHeld     <= 1'b0;
			wHeld      <= 1'b0;
			awAddrQ    <= 8'h00;
			wDataQ     <= 32'h0;
			wStrbQ     <= 4'h0;
			bvalid     <= 1'b0;
			bresp      <= `RESP_OKAY;
			stepPeriod <= 32'(STEP_PERIOD_CYCLES);
		end else begin
			if (awvalid && awready) begin
				awHeld  <= 1'b1;
				awAddrQ <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld  <= 1'b1;
				wDataQ <= wdata;
				wStrbQ <= wstrb;
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld  <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= wrPeriod ? `RESP_OKAY : `RESP_SLVERR;
				for (int i = 0; i < 4; i++) begin
					if (wrPeriod && wStrbQ[i]) begin
						stepPeriod[i*8 +: 8] <= wDataQ[i*8 +: 8];
					end
				end
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Read side: data captured when the address is taken
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= `RESP_OKAY;
		end else if (doRead) begin
			rvalid <= 1'b1;
			rdata  <= rdStatus ? statusWord : (rdPeriod ? stepPeriod : 32'h0);
			rresp  <= (rdStatus || rdPeriod) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// Checks on the stepping, storage and mode logic
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	a_level_range: assert property (level <= `LEVEL_TOP)
		else $error("volume level above top step");

	a_down_press: assert property (
		memOk && downHeld && !upHeld && $past(!downHeld) && !atBottom
		|=> level == $past(level) - `LEVEL_ONE)
		else $error("down press did not lower one step");

	a_up_press: assert property (
		memOk && upHeld && !downHeld && $past(!upHeld) && !atTop
		|=> level == $past(level) + `LEVEL_ONE)
		else $error("up press did not raise one step");

	a_repeat_step: assert property (
		memOk && upHeld && !downHeld && $past(upHeld) && $past(!downHeld)
		&& armed && stepTick && !atTop
		|=> level == $past(level) + `LEVEL_ONE)
		else $error("held up button did not repeat on tick");

	a_ext_priority: assert property (
		extActive && !extRise && memOk && heldDir == prevDir |=> $stable(level))
		else $error("oscillator ticked while external clock active");

	a_shutdown_hold: assert property (
		!running && memOk ##1 memOk |-> $stable(level))
		else $error("level changed during shutdown");

	a_supply_default: assert property (!memOk |=> level == `LEVEL_DEFAULT)
		else $error("default level not loaded on supply loss");

	a_input_route: assert property (
		pinSync[`PIN_INSEL] |=> phonesSelected && !lineSelected)
		else $error("phones input not routed");

	a_line_route: assert property (
		!pinSync[`PIN_INSEL] |=> lineSelected && !phonesSelected)
		else $error("line input not routed");

	a_se_gain: assert property (
		seSel |=> singleEndedMode && gainDb == 8'({2'b00, $past(level), 1'b0})
		+ `GAIN_BOTTOM_DB - `GAIN_SE_CUT_DB)
		else $error("single-ended gain not reduced");

	a_bridged_gain: assert property (
		!seSel |=> bridgedMode && gainDb == 8'({2'b00, $past(level), 1'b0})
		+ `GAIN_BOTTOM_DB)
		else $error("bridged gain not at full level");

	a_neg_float: assert property (
		singleEndedMode |-> !leftNegativeOutputEn && !rightNegativeOutputEn)
		else $error("negative outputs driven in single-ended mode");

	a_neg_driven: assert property (
		bridgedMode && ampEnable |-> leftNegativeOutputEn && rightNegativeOutputEn)
		else $error("negative outputs floating in bridged mode");

	a_shutdown_off: assert property (
		!running && memOk |=> !ampEnable ##0 $stable(level))
		else $error("amplifier active in shutdown");

	a_beep_detect: assert property (beepRise |=> beepMode)
		else $error("beep edge did not enter beep mode");

	a_top_saturate: assert property (memOk && atTop && stepUp |=> atTop)
		else $error("level stepped past top");

	a_bottom_saturate: assert property (memOk && atBottom && stepDown |=> atBottom)
		else $error("level stepped past bottom");

	a_hold_unarmed: assert property (
		memOk && heldDir == prevDir && !armed |=> $stable(level))
		else $error("held button stepped before repeat armed");
endmodule // stepped_volume_control

// ==== verif/button_panel.sv ====
`timescale 1ns/10ps
// Far side: two buttons, an external step clock source and a beep square wave
module button_panel (
	input  wire logic core_clk,
	input  wire logic upHold,
	input  wire logic downHold,
	input  wire logic extOn,
	input  wire logic beepOn,
	output logic      volumeUpN = 1'b1,
	output logic      volumeDownN = 1'b1,
	output logic      stepClockPin = 1'b0,
	output logic      beepInput = 1'b0
);
	logic [3:0] phase = 4'h0;

	// Buttons pull low while held; both generators stand still when off
	always_ff @(posedge core_clk) begin
		phase <= phase + 4'h1;
		volumeUpN <= !upHold;
		volumeDownN <= !downHold;
		stepClockPin <= extOn & phase[2];  // Rising edge every 8 cycles
		beepInput <= beepOn & phase[1];    // Square wave, period 4 cycles
	end
endmodule // button_panel

// ==== verif/stepped_volume_control_tb.sv ====
`timescale 1ns/10ps
// Self-checking bench: status bus, button stepping, pin modes and shutdown
module stepped_volume_control_tb;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        upHold = 1'b0;
	logic        downHold = 1'b0;
	logic        extOn = 1'b0;
	logic        beepOn = 1'b0;
	logic        inputSelect = 1'b0;
	logic        outputConfig = 1'b0;
	logic        shutdownN = 1'b1;
	logic        memorySupplyOk = 1'b1;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        volumeUpN, volumeDownN, stepClockPin, beepInput;
	logic [4:0]  volumeLevel;
	logic [7:0]  gainDb;
	logic        phonesSelected, lineSelected, singleEndedMode, bridgedMode;
	logic        leftNegativeOutputEn, rightNegativeOutputEn, ampEnable;
	logic        beepMode, extClockInUse;
	logic        d;
	logic        se = 1'b0;
	logic        ph = 1'b0;
	int          lvl = 15;
	int          err_total = 0;
	int          samples_checked = 0;

	always #5 core_clk = ~core_clk;

	stepped_volume_control #(
		.STEP_PERIOD_CYCLES(8),
		.EXT_TIMEOUT_CYCLES(16),
		.BEEP_TIMEOUT_CYCLES(16)
	) u_dut (
		.core_clk              (core_clk),
		.rst_n                 (rst_n),
		.awaddr                (awaddr),
		.awvalid               (awvalid),
		.awready               (awready),
		.wdata                 (wdata),
		.wstrb                 (wstrb),
		.wvalid                (wvalid),
		.wready                (wready),
		.bresp                 (bresp),
		.bvalid                (bvalid),
		.bready                (bready),
		.araddr                (araddr),
		.arvalid               (arvalid),
		.arready               (arready),
		.rdata                 (rdata),
		.rresp                 (rresp),
		.rvalid                (rvalid),
		.rready                (rready),
		.volumeUpN             (volumeUpN),
		.volumeDownN           (volumeDownN),
		.stepClockPin          (stepClockPin),
		.inputSelect           (inputSelect),
		.outputConfig          (outputConfig),
		.shutdownN             (shutdownN),
		.memorySupplyOk        (memorySupplyOk),
		.beepInput             (beepInput),
		.volumeLevel           (volumeLevel),
		.gainDb                (gainDb),
		.phonesSelected        (phonesSelected),
		.lineSelected          (lineSelected),
		.singleEndedMode       (singleEndedMode),
		.bridgedMode           (bridgedMode),
		.leftNegativeOutputEn  (leftNegativeOutputEn),
		.rightNegativeOutputEn (rightNegativeOutputEn),
		.ampEnable             (ampEnable),
		.beepMode              (beepMode),
		.extClockInUse         (extClockInUse)
	);

	button_panel u_panel (
		.core_clk     (core_clk),
		.upHold       (upHold),
		.downHold     (downHold),
		.extOn        (extOn),
		.beepOn       (beepOn),
		.volumeUpN    (volumeUpN),
		.volumeDownN  (volumeDownN),
		.stepClockPin (stepClockPin),
		.beepInput    (beepInput)
	);

	task automatic close_out();
		$display("Checks %0d, errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Model of the level and gain outputs
	task automatic check_level();
		check({27'h0, volumeLevel}, 32'(lvl));
		check({24'h0, gainDb}, {24'h0, 8'(2 * lvl - 40 - (se ? 6 : 0))});
	endtask

	function automatic int sat(input int v);
		return (v > 30) ? 30 : ((v < 0) ? 0 : v);
	endfunction

	function automatic logic [31:0] status(input logic sd, input logic bp, input logic ex);
		return {21'h0, memorySupplyOk, ex, bp, ph, se, sd, 5'(lvl)};
	endfunction

	// Write: address and data offered together, each released once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 50) begin
			err_total++;
			close_out();
		end
		check({30'h0, bresp}, {30'h0, er});
		tick(1);
	endtask

	task automatic axi_read(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		if (n == 50) begin
			err_total++;
			close_out();
		end
		check(rdata, ev);
		check({30'h0, rresp}, {30'h0, er});
		tick(1);
	endtask

	// Hold one button for len cycles, then release and let it settle
	task automatic press(input logic up, input int len);
		upHold <= up;
		downHold <= !up;
		tick(len);
		upHold <= 1'b0;
		downHold <= 1'b0;
		tick(8);
	endtask

	initial begin
		void'($urandom(40084));
		tick(16);
		rst_n <= 1'b1;
		tick(3);
		check_level();
		axi_read(8'h00, status(1'b0, 1'b0, 1'b0), 2'h0);
		axi_write(8'h04, 32'h8, 2'h0);
		axi_read(8'h04, 32'h8, 2'h0);
		axi_write(8'h00, 32'h1f, 2'h2);
		axi_write(8'h0c, 32'h1, 2'h2);
		axi_read(8'h0c, 32'h0, 2'h2);
		check_level();
		// Single presses, then long holds into both ends of the range
		press(1'b1, 3);
		lvl = 16;
		check_level();
		press(1'b0, 3);
		lvl = 15;
		check_level();
		press(1'b0, 300);
		lvl = 0;
		check_level();
		press(1'b0, 3);
		check_level();
		press(1'b1, 300);
		lvl = 30;
		check_level();
		press(1'b1, 3);
		check_level();
		for (int i = 0; i < 24; i++) begin
			d = 1'($urandom_range(1, 0));
			press(d, 3);
			lvl = sat(lvl + (d ? 1 : -1));
			check_level();
		end
		// Every combination of the routing and output pins
		for (int m = 0; m < 4; m++) begin
			inputSelect <= m[0];
			outputConfig <= m[1];
			ph = m[0];
			se = m[1];
			tick(6);
			check({28'h0, phonesSelected, lineSelected, singleEndedMode, bridgedMode},
				{28'h0, ph, !ph, se, !se});
			check({30'h0, leftNegativeOutputEn, rightNegativeOutputEn}, {30'h0, !se, !se});
			check_level();
			axi_read(8'h00, status(1'b0, 1'b0, 1'b0), 2'h0);
		end
		// Shutdown keeps the level and beep detection, blocks stepping
		outputConfig <= 1'b0;
		se = 1'b0;
		shutdownN <= 1'b0;
		beepOn <= 1'b1;
		tick(12);
		check({29'h0, ampEnable, leftNegativeOutputEn, beepMode}, 32'h1);
		press(1'b1, 3);
		check_level();
		axi_read(8'h00, status(1'b1, 1'b1, 1'b0), 2'h0);
		beepOn <= 1'b0;
		shutdownN <= 1'b1;
		tick(40);
		check({29'h0, ampEnable, leftNegativeOutputEn, beepMode}, 32'h6);
		check_level();
		// Slow internal oscillator, fast external clock must set the rate
		press(1'b1, 300);
		lvl = 30;
		axi_write(8'h04, 32'h3e8, 2'h0);
		extOn <= 1'b1;
		tick(20);
		check({31'h0, extClockInUse}, 32'h1);
		axi_read(8'h00, status(1'b0, 1'b0, 1'b1), 2'h0);
		press(1'b0, 60);
		check({31'h0, volumeLevel < 5'd27}, 32'h1);
		// Memory supply loss reloads the default and holds it
		memorySupplyOk <= 1'b0;
		tick(6);
		lvl = 15;
		check_level();
		press(1'b1, 3);
		check_level();
		axi_read(8'h00, status(1'b0, 1'b0, 1'b1), 2'h0);
		memorySupplyOk <= 1'b1;
		extOn <= 1'b0;
		tick(40);
		check({31'h0, extClockInUse}, 32'h0);
		axi_write(8'h04, 32'h8, 2'h0);
		press(1'b1, 3);
		lvl = 16;
		check_level();
		close_out();
	end
endmodule // stepped_volume_control_tb
